//--- rtl/rdrp_port.v
/*
  Recovery debug port: a minimal serial wire debug target on the shared
  multidrop bus. Handles line reset, target select, identity read and the
  control/status register whose power-up request bit starts a rescue.
  Assumes the probe clock is far slower than clock_i (5 MHz vs 40 MHz), a
  power-on reset on por_i, and software clear on flag_clear_i.
*/
`timescale 1ns/100ps
`default_nettype none
`include "rdrp_map.vh"
module rdrp_port #(
  parameter RESCUE_CYC = `RDRP_RESCUE_CYC  // Hard reset hold in cycles
) (
  input  wire clock_i,                    // Free running system clock
  input  wire rst_i,                      // Synchronous reset, active high
  input  wire por_i,                      // Power-on reset, clears the flag
  input  wire swclk_i,                    // Probe clock pin
  input  wire swdio_i,                    // Data pin input
  output reg  swdio_o,                    // Data pin output
  output reg  swdio_oe_n_o,               // Data pin enable, low drives
  input  wire flag_clear_i,               // Software clears rescue flag
  output reg  rescue_flag_o,              // Sticky rescue flag
  output reg  chip_reset_o,               // Chip-wide hard reset
  output reg  sys_clk_en_o                // System clock enable
);
  // ==========================================================
  // States
  localparam S_HDR  = 3'h0;
  localparam S_TURN = 3'h1;
  localparam S_ACK  = 3'h2;
  localparam S_RD   = 3'h3;
  localparam S_WTRN = 3'h4;
  localparam S_WR   = 3'h5;
  localparam S_RTRN = 3'h6;

  wire [1:0] s_w;                         // Synchronised pins
  reg        clk_old_q;                   // Previous clock level
  reg  [2:0] st_q;                        // Protocol state
  reg  [5:0] cnt_q;                       // Bit counter
  reg  [5:0] ones_q;                      // High bits in a row
  reg  [7:0] hdr_q;                       // Header shift
  reg [32:0] sh_q;                        // Data shift with parity
  reg        sel_q;                       // Selected by target select
  reg        tsel_q;                      // Next packet must be target select
  reg        is_tsel_q;                   // Current write is target select
  reg        pwrreq_q;                    // Power-up request bit
  reg [15:0] rcnt_q;                      // Rescue hold counter
  reg        rescue_act_q;                // Rescue reset in progress

  // RQ1: pin sampling
  rdrp_sync #(.W(2)) u_sync (
    .clock_i (clock_i),
    .async_i ({swdio_i, swclk_i}),
    .sync_o  (s_w)
  );

  wire rise_w = s_w[0] & ~clk_old_q;      // Port samples on rising
  wire fall_w = ~s_w[0] & clk_old_q;      // We drive on falling
  wire hdr_ok_w = hdr_q[`RDRP_HDR_START] & ~hdr_q[`RDRP_HDR_STOP] & hdr_q[`RDRP_HDR_PARK] &
                  (^hdr_q[`RDRP_HDR_A3:`RDRP_HDR_APNDP] == hdr_q[`RDRP_HDR_PAR]);
  wire [1:0] addr_w = {hdr_q[`RDRP_HDR_A3], hdr_q[`RDRP_HDR_A2]};
  wire rnw_w = hdr_q[`RDRP_HDR_RNW];
  wire dp_w  = ~hdr_q[`RDRP_HDR_APNDP];
  wire [2:0] ack_sh_w = `RDRP_ACK_OK >> cnt_q[1:0]; // Acknowledge bit now due in bit 0

  // ==========================================================
  // Serial protocol engine
  always @(posedge clock_i) begin
    if (rst_i && !rescue_act_q) begin
      clk_old_q    <= 1'b0;
      st_q         <= S_HDR;
      cnt_q        <= 6'h0;
      ones_q       <= 6'h0;
      hdr_q        <= 8'h0;
      sh_q         <= 33'h0;
      sel_q        <= 1'b0;
      tsel_q       <= 1'b0;
      is_tsel_q    <= 1'b0;
      pwrreq_q     <= 1'b0;
      swdio_o      <= 1'b1;
      swdio_oe_n_o <= 1'b1;
    end else begin
      clk_old_q <= s_w[0];
      if (rise_w) begin
        // Line reset detection, drops selection
        if (s_w[1]) begin
          if (ones_q != `RDRP_LINE_RESET_LEN)
            ones_q <= ones_q + 6'h1;
        end else
          ones_q <= 6'h0;
        // Ones past the threshold stay in line reset, never a start bit
        if (s_w[1] && ones_q >= `RDRP_LINE_RESET_LEN - 6'h1) begin
          // RQ7: line reset deselects
          sel_q  <= 1'b0;
          tsel_q <= 1'b1;
          st_q   <= S_HDR;
          cnt_q  <= 6'h0;
        end else begin
          case (st_q)
            S_HDR: begin
              // Wait for start bit, then shift in 8 header bits counting the start bit
              if (cnt_q != 6'h0 || s_w[1]) begin
                hdr_q <= {s_w[1], hdr_q[7:1]};
                cnt_q <= cnt_q + 6'h1;
                if (cnt_q == `RDRP_HDR_LAST) begin
                  cnt_q <= 6'h0;
                  st_q  <= S_TURN;
                end
              end
            end
            S_TURN: begin
              // Header complete; target select has no answer phase
              is_tsel_q <= dp_w && !rnw_w && addr_w == `RDRP_ADDR_TSEL && tsel_q;
              if (!hdr_ok_w)
                st_q <= S_HDR;
              else if (dp_w && !rnw_w && addr_w == `RDRP_ADDR_TSEL && tsel_q)
                st_q <= S_WTRN;
              else if (sel_q)
                st_q <= S_ACK;
              else
                st_q <= S_HDR;
            end
            S_ACK: begin
              cnt_q <= cnt_q + 6'h1;
              if (cnt_q == `RDRP_ACK_LAST) begin
                cnt_q <= 6'h0;
                st_q  <= rnw_w ? S_RD : S_WTRN;
              end
            end
            S_RD: begin
              cnt_q <= cnt_q + 6'h1;
              if (cnt_q == `RDRP_DATA_LAST) begin
                cnt_q <= 6'h0;
                st_q  <= S_RTRN;
              end
            end
            S_RTRN: st_q <= S_HDR;
            S_WTRN: st_q <= S_WR;
            S_WR: begin
              sh_q  <= {s_w[1], sh_q[32:1]};
              cnt_q <= cnt_q + 6'h1;
              if (cnt_q == `RDRP_DATA_LAST) begin
                cnt_q <= 6'h0;
                st_q  <= S_HDR;
                // Check parity over the 32 data bits
                if (^sh_q[32:1] == s_w[1]) begin
                  if (is_tsel_q) begin
                    // RQ7: select on own identity only
                    sel_q  <= (sh_q[32:1] == `RDRP_TARGET_ID);
                    tsel_q <= 1'b0;
                  end else if (dp_w && addr_w == `RDRP_ADDR_CTRL) begin
                    // RQ2: request bit write
                    pwrreq_q <= sh_q[`RDRP_CTRL_PWRREQ + 1];
                  end
                end
              end
            end
            default: st_q <= S_HDR;
          endcase
        end
      end
      // Drive the line on falling edges; released when not answering
      if (fall_w) begin
        // RQ7: tristate unless answering
        swdio_oe_n_o <= !(st_q == S_ACK || (st_q == S_RD && cnt_q != 6'h0) ||
                          (st_q == S_RD && cnt_q == 6'h0));
        if (st_q == S_ACK)
          swdio_o <= ack_sh_w[0];
        else if (st_q == S_RD)
          swdio_o <= (cnt_q == `RDRP_DATA_LAST) ? ^sh_q[31:0] : sh_q[cnt_q[4:0]];
        else
          swdio_o <= 1'b1;
      end
      // Load read data at the end of the acknowledge
      if (rise_w && st_q == S_ACK && cnt_q == `RDRP_ACK_LAST && rnw_w) begin
        if (addr_w == `RDRP_ADDR_IDCODE)
          sh_q <= {1'b0, `RDRP_TARGET_ID};
        else if (addr_w == `RDRP_ADDR_CTRL)
          // Request and its acknowledge read back side by side
          sh_q <= ({32'h00000000, pwrreq_q} << `RDRP_CTRL_PWRREQ) |
                  ({32'h00000000, pwrreq_q} << `RDRP_CTRL_PWRACK);
        else
          sh_q <= 33'h0;
      end
      // Rescue done: request is consumed so it does not retrigger
      if (rescue_act_q && rcnt_q == 16'h1)
        pwrreq_q <= 1'b0;
    end
  end

  // ==========================================================
  // Rescue sequencing and sticky flag
  always @(posedge clock_i) begin
    if (por_i) begin
      // RQ8: power-on clears flag, rescue reset does not
      rescue_flag_o <= 1'b0;
      rescue_act_q  <= 1'b0;
      rcnt_q        <= 16'h0;
      chip_reset_o  <= 1'b0;
      sys_clk_en_o  <= 1'b1;
    end else begin
      // RQ6: clock always left running
      sys_clk_en_o <= 1'b1;
      if (pwrreq_q && !rescue_act_q) begin
        // RQ3: start chip hard reset
        rescue_act_q <= 1'b1;
        rcnt_q       <= RESCUE_CYC[15:0];
        chip_reset_o <= 1'b1;
      end else if (rescue_act_q) begin
        rcnt_q <= rcnt_q - 16'h1;
        if (rcnt_q == 16'h1) begin
          rescue_act_q <= 1'b0;
          chip_reset_o <= 1'b0;
        end
      end
      // RQ4: set flag, set beats clear
      if (pwrreq_q && !rescue_act_q)
        rescue_flag_o <= 1'b1;
      // RQ5: software clear
      else if (flag_clear_i)
        rescue_flag_o <= 1'b0;
    end
  end
endmodule // rdrp_port
`default_nettype wire

//--- include/rdrp_map.vh
/*
  Constants for the recovery debug port: serial wire protocol fields,
  control/status bit positions, target identity and reset timing.
  Assumes it is included by bare name from the design files.
*/
// Notes on behaviour
// RQ1: Port reachable on shared serial wire bus
// RQ2: Power-up request bit set triggers rescue
// RQ3: Rescue drives chip-wide power-on-like hard reset
// RQ4: Rescue sets sticky flag in reset logic
// RQ5: Flag holds until software clears it
// RQ6: System clock keeps running after rescue
// RQ7: Answer only after matching target-select
// RQ8: Rescue reset never clears the flag
`ifndef RDRP_MAP_VH
`define RDRP_MAP_VH
// ==========================================================
// Target identity (arbitrary value, not a real part code)
`define RDRP_TARGET_ID      32'h0badc0de
// ==========================================================
// Packet header bit positions
`define RDRP_HDR_START      3'h0
`define RDRP_HDR_APNDP      3'h1
`define RDRP_HDR_RNW        3'h2
`define RDRP_HDR_A2         3'h3
`define RDRP_HDR_A3         3'h4
`define RDRP_HDR_PAR        3'h5
`define RDRP_HDR_STOP       3'h6
`define RDRP_HDR_PARK       3'h7
// Register address field values (A3:A2)
`define RDRP_ADDR_IDCODE    2'h0
`define RDRP_ADDR_CTRL      2'h1
`define RDRP_ADDR_RDBUF     2'h3
`define RDRP_ADDR_TSEL      2'h3
// Acknowledge codes, sent lsb first
`define RDRP_ACK_OK         3'h1
// Control/status power-up request bit and its acknowledge
`define RDRP_CTRL_PWRREQ    5'h1c
`define RDRP_CTRL_PWRACK    5'h1d
// ==========================================================
// Line reset: at least this many high bits
`define RDRP_LINE_RESET_LEN 6'h32
// Last bit index of each packet phase, counted from zero
`define RDRP_HDR_LAST       6'h07
`define RDRP_ACK_LAST       6'h02
`define RDRP_DATA_LAST      6'h20
// Rescue hard reset hold, in microseconds, and its cycle count at 40 MHz
`define RDRP_RESCUE_US      16'h000a
`define RDRP_CLK_MHZ        16'h0028
`define RDRP_RESCUE_CYC     (`RDRP_RESCUE_US * `RDRP_CLK_MHZ)
`endif

//--- rtl/rdrp_sync.v
/*
  Two flip-flop synchroniser, one chain per bit.
  Assumes inputs are asynchronous to clock_i.
*/
`timescale 1ns/100ps
`default_nettype none
module rdrp_sync #(
  parameter W = 2                         // Bits to synchronise
) (
  input  wire         clock_i,            // Core clock
  input  wire [W-1:0] async_i,            // Asynchronous inputs
  output wire [W-1:0] sync_o              // Synchronised outputs
);
  // ==========================================================
  // Synchroniser chain per bit
  genvar g;
  generate
    for (g = 0; g < W; g = g + 1) begin : g_bit
      reg meta_q;                         // First stage, read only by second
      reg sync_q;                         // Second stage
      always @(posedge clock_i) begin
        meta_q <= async_i[g];
        sync_q <= meta_q;
      end
      assign sync_o[g] = sync_q;
    end
  endgenerate
endmodule // rdrp_sync
`default_nettype wire

//--- testbench/rdrp_props.sv
/* Pin checker for the recovery debug port.
   Assumes bind to rdrp_port and a por_i pulse at start. */
`timescale 1ns/100ps
`default_nettype none
module rdrp_props #(
  parameter int RESCUE_CYC = 8       // Hold cycles
) (
  input wire logic clock_i,          // Clock
  input wire logic rst_i,            // Port reset
  input wire logic por_i,            // Power-on reset
  input wire logic swclk_i,          // Probe clock
  input wire logic swdio_i,          // Data in
  input wire logic swdio_o,          // Data out
  input wire logic swdio_oe_n_o,     // Drive, low
  input wire logic flag_clear_i,     // Flag clear
  input wire logic rescue_flag_o,    // Rescue flag
  input wire logic chip_reset_o,     // Chip reset
  input wire logic sys_clk_en_o      // Clock enable
);
  logic       sw_q;                  // Probe clock last
  logic [7:0] edges_q;               // Probe edges since reset
  logic [9:0] hold_q;                // Reset high run
  // ==========================================
  // Helpers: a port must see a whole select first
  always @(posedge clock_i) begin
    sw_q <= swclk_i;
    hold_q <= chip_reset_o ? hold_q + 10'h001 : 10'h000;
    if (rst_i) begin
      edges_q <= 8'h00;
    end else if (swclk_i && !sw_q && edges_q != 8'hff) begin
      edges_q <= edges_q + 8'h01;
    end
  end
  // ==========================================
  // Properties
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (por_i);
  sequence rescue_start; $rose(chip_reset_o); endsequence
  sequence rescue_end; $fell(chip_reset_o); endsequence
  oe_idle_a: assert property (rst_i && !chip_reset_o |=> swdio_oe_n_o)
    else $error("port drives after reset");
  select_first_a: assert property (disable iff (por_i || rst_i) !swdio_oe_n_o |-> edges_q >= 8'h64)
    else $error("port drives before select");
  clock_run_a: assert property (sys_clk_en_o)
    else $error("system clock stopped");
  flag_set_a: assert property (rescue_start |-> rescue_flag_o)
    else $error("rescue without flag");
  hold_len_a: assert property (rescue_end |-> hold_q == RESCUE_CYC)
    else $error("hard reset length wrong");
  hold_max_a: assert property (chip_reset_o |-> hold_q < RESCUE_CYC)
    else $error("hard reset too long");
  flag_keep_a: assert property (rescue_flag_o && !flag_clear_i |=> rescue_flag_o)
    else $error("flag lost");
  flag_clear_a: assert property (rescue_flag_o && flag_clear_i && !chip_reset_o |=>
    !rescue_flag_o || $rose(chip_reset_o)) // A rescue set in the same cycle wins
    else $error("flag not cleared");
  rescue_cause_a: assert property (rescue_start |-> edges_q >= 8'h80)
    else $error("rescue without request");
endmodule // rdrp_props
bind rdrp_port rdrp_props #(.RESCUE_CYC(RESCUE_CYC)) props_i (.clock_i(clock_i), .rst_i(rst_i),
  .por_i(por_i), .swclk_i(swclk_i), .swdio_i(swdio_i), .swdio_o(swdio_o), .swdio_oe_n_o(swdio_oe_n_o),
  .flag_clear_i(flag_clear_i), .rescue_flag_o(rescue_flag_o), .chip_reset_o(chip_reset_o),
  .sys_clk_en_o(sys_clk_en_o));
`default_nettype wire

//--- testbench/rdrp_probe.sv
/* Debug probe model: clocks frames and drives the data line.
   Assumes a pull-up on the line; clock still outside frames. */
`timescale 1ns/100ps
`default_nettype none
module rdrp_probe (
  input  wire logic clock_i,         // Bench clock
  input  wire logic dio_i,           // Port data out
  input  wire logic oe_n_i,          // Port drive, low
  output var  logic swclk_o,         // Probe clock
  output wire logic line_o           // Resolved line
);
  logic drv = 1'b0;                  // Probe drives
  logic bit_v = 1'b1;                // Probe value
  // Pull-up wins when nobody drives
  assign line_o = !oe_n_i ? dio_i : (drv ? bit_v : 1'b1);
  initial swclk_o = 1'b0;
  // One 200 ns bit; sample late in the high phase
  task automatic cyc(input logic d, input logic b, output logic r);
    drv = d;
    bit_v = b;
    repeat (4) @(negedge clock_i);
    swclk_o = 1'b1;
    repeat (4) @(negedge clock_i);
    r = line_o;
    swclk_o = 1'b0;
  endtask
  task automatic line_reset;
    logic r;
    for (int i = 0; i < 54; i++) cyc(1'b1, i < 52, r);
    drv = 1'b0;
  endtask
  // packet; select form has no ack
  task automatic xfer(input logic [7:0] hdr, input logic sel, input logic [31:0] wd,
                      input logic bad, output logic [2:0] ack, output logic [31:0] rd);
    logic r;
    ack = 3'h7;
    rd = 32'h0;
    for (int i = 0; i < 8; i++) cyc(1'b1, hdr[i], r);
    cyc(1'b0, 1'b1, r);
    if (!sel) for (int i = 0; i < 3; i++) cyc(1'b0, 1'b1, ack[i]);
    if (hdr[2]) begin
      for (int i = 0; i < 34; i++) begin
        cyc(1'b0, 1'b1, r);
        if (i < 32) rd[i] = r;
      end
    end else begin
      // Second turnaround, ahead of select data as well
      cyc(1'b0, 1'b1, r);
      for (int i = 0; i < 33; i++) cyc(1'b1, (i < 32) ? wd[i] : (^wd) ^ bad, r);
    end
    drv = 1'b0;
  endtask
endmodule // rdrp_probe
`default_nettype wire

//--- testbench/rescue_debug_reset_port_tb.sv
/* Testbench for the recovery debug port.
   Assumes rdrp_port, the probe model and the bound checker. */
`timescale 1ns/100ps
`default_nettype none
`include "rdrp_map.vh"
module rescue_debug_reset_port_tb;
  localparam int HOLD = 8;           // Short rescue hold
  logic        clock_i, rst_i, por_i, flag_clear_i;
  wire         swclk, line, dio, oe_n, flag, creset, clk_en;
  logic [2:0]  ack;                  // Last ack
  logic [31:0] rd;                   // Last read
  int          hold_n = 0;           // Reset high count
  int          error_cnt = 0;        // Mismatches
  int          checks_done = 0;      // Comparisons
  rdrp_port #(.RESCUE_CYC(HOLD)) dut (.clock_i(clock_i), .rst_i(rst_i), .por_i(por_i), .swclk_i(swclk),
    .swdio_i(line), .swdio_o(dio), .swdio_oe_n_o(oe_n), .flag_clear_i(flag_clear_i),
    .rescue_flag_o(flag), .chip_reset_o(creset), .sys_clk_en_o(clk_en));
  rdrp_probe probe (.clock_i(clock_i), .dio_i(dio), .oe_n_i(oe_n), .swclk_o(swclk), .line_o(line));
  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end
  always @(negedge clock_i) if (creset === 1'b1) hold_n++;
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up;
    $display("Checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic sel_id(input logic [31:0] id);
    probe.line_reset();
    probe.xfer(8'h99, 1'b1, id, 1'b0, ack, rd);
  endtask
  // Wrong identity: port must stay silent
  task automatic t_quiet;
    sel_id(~`RDRP_TARGET_ID);
    probe.xfer(8'ha5, 1'b0, 32'h0, 1'b0, ack, rd);
    check("quiet ack", ack, 3'h7);
    check("quiet data", rd, 32'hffffffff);
  endtask
  // Bad parity and a clear bit start nothing
  task automatic t_refuse;
    sel_id(`RDRP_TARGET_ID);
    probe.xfer(8'ha5, 1'b0, 32'h0, 1'b0, ack, rd);
    check("id ack", ack, `RDRP_ACK_OK);
    check("id data", rd, `RDRP_TARGET_ID);
    probe.xfer(8'ha9, 1'b0, 32'h10000000, 1'b1, ack, rd);
    probe.xfer(8'h8d, 1'b0, 32'h0, 1'b0, ack, rd);
    check("ctrl ack", ack, `RDRP_ACK_OK);
    check("ctrl read", rd, 32'h0);
    probe.xfer(8'ha9, 1'b0, 32'h0, 1'b0, ack, rd);
    repeat (40) @(negedge clock_i);
    check("no rescue", hold_n, 0);
  endtask
  task automatic t_rescue;
    int n;
    sel_id(`RDRP_TARGET_ID);
    hold_n = 0;
    probe.xfer(8'ha9, 1'b0, 32'h10000000, 1'b0, ack, rd);
    check("write ack", ack, `RDRP_ACK_OK);
    for (n = 0; n < 300 && hold_n == 0; n++) @(negedge clock_i);
    if (n == 300) begin
      check("start wait", n, 0);
      wrap_up();
    end
    check("flag set", flag, 1'b1);
    for (n = 0; n < 300 && creset !== 1'b0; n++) @(negedge clock_i);
    if (n == 300) begin
      check("end wait", n, 0);
      wrap_up();
    end
    check("hold cycles", hold_n, HOLD);
    check("clock on", clk_en, 1'b1);
    rst_i = 1'b1;
    repeat (2) @(negedge clock_i);
    rst_i = 1'b0;
    @(negedge clock_i);
    check("flag kept", flag, 1'b1);
    check("reset drive", oe_n, 1'b1);
  endtask
  // Software clear drops the flag
  task automatic t_clear;
    flag_clear_i = 1'b1;
    @(negedge clock_i);
    flag_clear_i = 1'b0;
    @(negedge clock_i);
    check("flag cleared", flag, 1'b0);
  endtask
  // Power-on reset drops the flag
  task automatic t_por;
    por_i = 1'b1;
    @(negedge clock_i);
    por_i = 1'b0;
    @(negedge clock_i);
    check("por clears", flag, 1'b0);
  endtask
  initial begin
    rst_i = 1'b1;
    por_i = 1'b1;
    flag_clear_i = 1'b0;
    repeat (12) @(negedge clock_i);
    rst_i = 1'b0;
    por_i = 1'b0;
    repeat (2) @(negedge clock_i);
    check("idle drive", oe_n, 1'b1);
    check("idle flag", flag, 1'b0);
    t_quiet();
    t_refuse();
    t_rescue();
    t_clear();
    t_rescue();
    t_por();
    wrap_up();
  end
endmodule // rescue_debug_reset_port_tb
`default_nettype wire
